// File: pll_cfg_consts.vh
`ifndef PLL_CFG_CONSTS_VH
`define PLL_CFG_CONSTS_VH

// ----------------------------------------
// Serial word layout
// ----------------------------------------
`define WORD_W            24
`define SEL_MSB           2
`define SEL_LSB           0
`define SYNC_STAGES       2

// ----------------------------------------
// Select codes
// ----------------------------------------
`define SEL_INT_DIV       3'h0
`define SEL_MOD_DIV       3'h1
`define SEL_FRAC_DIV      3'h2
`define SEL_DITHER        3'h3
`define SEL_PUMP_REF      3'h4
`define SEL_LO_MIX        3'h5
`define SEL_OSC_EN        3'h6
`define SEL_EXT_OSC       3'h7

// ----------------------------------------
// Register 0 fields
// ----------------------------------------
`define DIV_MODE_BIT      10
`define INT_DIV_MSB       9
`define INT_DIV_LSB       3

// ----------------------------------------
// Registers 1 and 2 fields
// ----------------------------------------
`define MODULUS_MSB       13
`define MODULUS_LSB       3
`define NUMER_MSB         13
`define NUMER_LSB         3

// ----------------------------------------
// Register 3 fields
// ----------------------------------------
`define DITH_MAG_MSB      22
`define DITH_MAG_LSB      21
`define DITH_ON_BIT       20
`define DITH_RST_MSB      19
`define DITH_RST_LSB      3

// ----------------------------------------
// Register 4 fields
// ----------------------------------------
`define REF_IN_MSB        23
`define REF_IN_LSB        21
`define REF_PATH_MSB      20
`define REF_PATH_LSB      19
`define PUMP_REF_BIT      18
`define PH_POL_BIT        17
`define PH_MULT_MSB       16
`define PH_MULT_LSB       12
`define CUR_MULT_MSB      11
`define CUR_MULT_LSB      10
`define CTL_SRC_BIT       9
`define CTL_FLD_MSB       8
`define CTL_FLD_LSB       7
`define EDGE_MSB          6
`define EDGE_LSB          5
`define ABL_MSB           4
`define ABL_LSB           3

// ----------------------------------------
// Register 5 fields
// ----------------------------------------
`define LIN_CAP_MSB       11
`define LIN_CAP_LSB       8
`define MIX_BIAS_BIT      7
`define SYNTH_ON_BIT      6
`define LO_DIV_BIT        5
`define LO_IO_BIT         4
`define LO_DRV_BIT        3

// ----------------------------------------
// Register 6 fields
// ----------------------------------------
`define PUMP_ON_BIT       20
`define AUX_REG_BIT       19
`define OSC_REG_BIT       18
`define OSC_ON_BIT        17
`define OSC_SW_BIT        16
`define OSC_AMP_MSB       15
`define OSC_AMP_LSB       10
`define BAND_SRC_BIT      9
`define BAND_MSB          8
`define BAND_LSB          3

// ----------------------------------------
// Register 7 fields
// ----------------------------------------
`define EXT_OSC_BIT       22

// ----------------------------------------
// Reset value of every register
// ----------------------------------------
`define REG_RESET         24'h00_0000

`endif

// File: pin_sync.v
`timescale 1ns/1ps
`default_nettype none
`include "pll_cfg_consts.vh"

// Two-flop synchroniser for one pin; first stage feeds only the second
module pin_sync
(
   input  wire ref_clk,
   input  wire sys_rst,
   input  wire clkEn,
   input  wire pinIn,
   output wire pinOut
);

   reg [`SYNC_STAGES-1:0] stage_reg;   // Synchroniser chain

   // ----------------------------------------
   // Shift chain
   // ----------------------------------------
   always @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         stage_reg <= {`SYNC_STAGES{1'b0}};
      end
      else if (clkEn)
      begin
         stage_reg <= {stage_reg[`SYNC_STAGES-2:0], pinIn};
      end
   end

   assign pinOut = stage_reg[`SYNC_STAGES-1];

endmodule // pin_sync
`default_nettype wire

// File: serial_shifter.v
`timescale 1ns/1ps
`default_nettype none
`include "pll_cfg_consts.vh"

// Shifts serial data in MSB first on each rising link clock edge,
// then presents a one-cycle commit pulse when load rises
module serial_shifter
#(
   parameter WIDTH = `WORD_W
)
(
   input  wire             ref_clk,
   input  wire             sys_rst,
   input  wire             clkEn,
   input  wire             sclkSync,
   input  wire             dataSync,
   input  wire             loadSync,
   output reg  [WIDTH-1:0] word_reg,
   output reg              commit_reg
);

   reg             sclkPrev_reg;   // Last link clock level
   reg             loadPrev_reg;   // Last load level
   reg [WIDTH-1:0] shift_reg;      // Incoming bits

   // ----------------------------------------
   // Edge detection, shifting and commit
   // ----------------------------------------
   always @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sclkPrev_reg <= 1'b0;
         loadPrev_reg <= 1'b0;
         shift_reg    <= {WIDTH{1'b0}};
         word_reg     <= {WIDTH{1'b0}};
         commit_reg   <= 1'b0;
      end
      else if (clkEn)
      begin
         sclkPrev_reg <= sclkSync;
         loadPrev_reg <= loadSync;
         commit_reg   <= 1'b0;
         if (sclkSync && !sclkPrev_reg)
         begin
            shift_reg <= {shift_reg[WIDTH-2:0], dataSync};
         end
         if (loadSync && !loadPrev_reg)
         begin
            word_reg   <= shift_reg;
            commit_reg <= 1'b1;
         end
      end
   end

endmodule // serial_shifter
`default_nettype wire

// File: pll_mixer_config_registers.v
`timescale 1ns/1ps
`default_nettype none
`include "pll_cfg_consts.vh"

// What this block does
// - Configuration only through three-wire serial port
// - Eight loadable registers, 24 bits each
// - Low three bits select the target register
// - Reg 0: mode bit 10, integer 9:3
// - Reg 1: 11-bit modulus in 13:3
// - Reg 2: 11-bit numerator in 13:3
// - Reg 3: dither magnitude, enable, restart value
// - Reg 4: reference, pump and detector fields
// - Reg 5: linearizer, mixer bias, LO controls
// - Reg 6: pump, regulators, oscillator, band select
// - Reg 7: external oscillator enable bit 22
// - Divider register writes start band calibration
// - Mode bit picks fractional or integer division
module pll_mixer_config_registers
(
   // Clock, reset and enable
   input  wire        ref_clk,
   input  wire        sys_rst,
   input  wire        clkEn,
   // Three-wire serial port
   input  wire        serClk,
   input  wire        serData,
   input  wire        serLoad,
   // Divider controls
   output reg         divide_mode_sel,
   output reg  [6:0]  int_divide_value,
   output reg  [10:0] modulus_value,
   output reg  [10:0] numerator_value,
   output reg         fracModeActive,
   output reg         calStart,
   // Modulator dither
   output reg  [1:0]  dither_magnitude,
   output reg         dither_on,
   output reg  [16:0] dither_restart_value,
   // Pump, detector and reference path
   output reg  [2:0]  ref_input_source,
   output reg  [1:0]  ref_path_source,
   output reg         pump_reference_sel,
   output reg         phase_offset_polarity,
   output reg  [4:0]  phase_offset_multiplier,
   output reg  [1:0]  pump_current_multiplier,
   output reg         pump_control_source,
   output reg  [1:0]  pump_control_field,
   output reg  [1:0]  detector_edge_sense,
   output reg  [1:0]  antibacklash_delay,
   // LO path and mixer
   output reg  [3:0]  linearizer_cap_setting,
   output reg         mixer_bias_on,
   output reg         synth_on,
   output reg         lo_div_select,
   output reg         lo_in_out_select,
   output reg         lo_driver_on,
   // Oscillator and enables
   output reg         pump_on,
   output reg         aux_regulator_on,
   output reg         osc_regulator_on,
   output reg         osc_on,
   output reg         osc_switch_ctrl,
   output reg  [5:0]  osc_amplitude,
   output reg         band_select_source,
   output reg  [5:0]  band_select_value,
   // External oscillator
   output reg         ext_osc_on
);

   // ----------------------------------------
   // Signals
   // ----------------------------------------
   wire                sclkSync;     // Link clock after synchroniser
   wire                dataSync;     // Data after synchroniser
   wire                loadSync;     // Load after synchroniser
   wire [`WORD_W-1:0]  word;         // Captured serial word
   wire                commit;       // One-cycle commit pulse
   wire [2:0]          selCode;      // Target register code
   reg  [`WORD_W-1:0]  bank_reg [0:7];  // Eight configuration words
   integer             idx;          // Reset loop index

   // Write-only: no word can be read back.
   // A frame under 24 bits keeps stale upper bits.
   // Each link clock phase needs three ref_clk cycles.
   // Calibration runs outside; calStart only marks
   // that a divider word was loaded.
   // Reset zeroes every word, so all controls start off except fracModeActive, which goes high one cycle after reset.
   // Enable low also freezes the synchronisers: pin
   // edges seen meanwhile are lost.
   // Divider values are passed on unchecked.
   // The link clock idles low; a high idle level
   // would give one false edge after reset.
   // Host write order and delays are not checked here.

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   // Pins are asynchronous; two flops each keep metastable
   // levels away from the edge detectors.
   // Link clock pin
   // serial pins only
   pin_sync u_syncClk
   (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .clkEn   (clkEn),
      .pinIn   (serClk),
      .pinOut  (sclkSync)
   );

   // Data pin, same delay as the clock
   pin_sync u_syncData
   (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .clkEn   (clkEn),
      .pinIn   (serData),
      .pinOut  (dataSync)
   );

   // Load strobe pin
   pin_sync u_syncLoad
   (
      .ref_clk (ref_clk),
      .sys_rst (sys_rst),
      .clkEn   (clkEn),
      .pinIn   (serLoad),
      .pinOut  (loadSync)
   );

   // ----------------------------------------
   // Serial shift register
   // ----------------------------------------
   // Data and clock share the same sync delay, so their relation
   // holds; the link clock must stay well under ref_clk / 4.
   // The shifter is not cleared by a load, so only the last
   // 24 bits of a longer frame count. Edges are found by
   // comparing each sample with the one before.
   serial_shifter #(.WIDTH(`WORD_W)) u_shift
   (
      .ref_clk    (ref_clk),
      .sys_rst    (sys_rst),
      .clkEn      (clkEn),
      .sclkSync   (sclkSync),
      .dataSync   (dataSync),
      .loadSync   (loadSync),
      .word_reg   (word),
      .commit_reg (commit)
   );

   // Code is taken from the committed word, not the live
   // shifter, so it cannot change under a store.
   // select code decode
   assign selCode = word[`SEL_MSB:`SEL_LSB];

   // ----------------------------------------
   // Register bank write
   // ----------------------------------------
   // Whole word is stored; the fields below pick only defined bits,
   // so reserved bits written as one have no effect.
   // A second word with the same code simply overwrites the
   // first; there is no write protection.
   always @(posedge ref_clk or posedge sys_rst)
   begin
      // Reset clears all eight words
      if (sys_rst)
      begin
         for (idx = 0; idx < 8; idx = idx + 1)
         begin
            bank_reg[idx] <= `REG_RESET;
         end
      end
      // Store only on a commit while enabled
      else if (clkEn && commit)
      begin
         // Code picks the word; no other word moves
         // independent load
         bank_reg[selCode] <= word;
      end
   end

   // ----------------------------------------
   // Calibration start pulse
   // ----------------------------------------
   // One ref_clk pulse, set on the same edge that stores the word.
   // Every divider load gives its own pulse, in any order,
   // so a 2, 1, 0 frequency change yields three of them.
   // Codes 3 to 7 never start one.
   // The pulse is registered, so it leaves a flip-flop.
   always @(posedge ref_clk or posedge sys_rst)
   begin
      // No pulse during reset
      if (sys_rst)
      begin
         calStart <= 1'b0;
      end
      // Pulse lasts one enabled cycle
      else if (clkEn)
      begin
         calStart <= commit && ((selCode == `SEL_INT_DIV) ||
                                (selCode == `SEL_MOD_DIV) ||
                                (selCode == `SEL_FRAC_DIV));
      end
   end

   // ----------------------------------------
   // Field outputs
   // ----------------------------------------
   // Registered so every output leaves a flip-flop; adds one cycle
   // after the bank update.
   // Reserved bits never reach an output, so a host that sets
   // them cannot disturb any control.
   always @(posedge ref_clk or posedge sys_rst)
   begin
      // All controls off during reset
      if (sys_rst)
      begin
         // Divider fields
         divide_mode_sel         <= 1'b0;
         int_divide_value        <= 7'h00;
         modulus_value           <= 11'h000;
         numerator_value         <= 11'h000;
         fracModeActive          <= 1'b0;

         // Dither fields
         dither_magnitude        <= 2'h0;
         dither_on               <= 1'b0;
         dither_restart_value    <= 17'h0_0000;

         // Pump, detector and reference fields
         ref_input_source        <= 3'h0;
         ref_path_source         <= 2'h0;
         pump_reference_sel      <= 1'b0;
         phase_offset_polarity   <= 1'b0;
         phase_offset_multiplier <= 5'h00;
         pump_current_multiplier <= 2'h0;
         pump_control_source     <= 1'b0;
         pump_control_field      <= 2'h0;
         detector_edge_sense     <= 2'h0;
         antibacklash_delay      <= 2'h0;

         // LO path and mixer fields
         linearizer_cap_setting  <= 4'h0;
         mixer_bias_on           <= 1'b0;
         synth_on                <= 1'b0;
         lo_div_select           <= 1'b0;
         lo_in_out_select        <= 1'b0;
         lo_driver_on            <= 1'b0;

         // Oscillator and regulator fields
         pump_on                 <= 1'b0;
         aux_regulator_on        <= 1'b0;
         osc_regulator_on        <= 1'b0;
         osc_on                  <= 1'b0;
         osc_switch_ctrl         <= 1'b0;
         osc_amplitude           <= 6'h00;
         band_select_source      <= 1'b0;
         band_select_value       <= 6'h00;

         // External oscillator field
         ext_osc_on              <= 1'b0;
      end
      // Follow the bank only while enabled
      else if (clkEn)
      begin
         // Bits 23:11 of word 0 are dropped
         // integer divide word
         divide_mode_sel  <= bank_reg[0][`DIV_MODE_BIT];
         int_divide_value <= bank_reg[0][`INT_DIV_MSB:`INT_DIV_LSB];
         // Mode bit low selects fractional division
         // fractional versus integer
         fracModeActive   <= ~bank_reg[0][`DIV_MODE_BIT];

         // Bits 23:14 of words 1 and 2 are dropped
         // modulus word
         modulus_value    <= bank_reg[1][`MODULUS_MSB:`MODULUS_LSB];

         // Numerator is not checked against modulus
         // numerator word
         numerator_value  <= bank_reg[2][`NUMER_MSB:`NUMER_LSB];

         // Bit 23 of word 3 is dropped
         // dither word
         dither_magnitude     <=
            bank_reg[3][`DITH_MAG_MSB:`DITH_MAG_LSB];
         dither_on            <= bank_reg[3][`DITH_ON_BIT];
         dither_restart_value <=
            bank_reg[3][`DITH_RST_MSB:`DITH_RST_LSB];

         // Word 4 uses every bit above the code
         // pump and reference word
         ref_input_source        <=
            bank_reg[4][`REF_IN_MSB:`REF_IN_LSB];
         ref_path_source         <=
            bank_reg[4][`REF_PATH_MSB:`REF_PATH_LSB];
         pump_reference_sel      <= bank_reg[4][`PUMP_REF_BIT];
         phase_offset_polarity   <= bank_reg[4][`PH_POL_BIT];
         phase_offset_multiplier <=
            bank_reg[4][`PH_MULT_MSB:`PH_MULT_LSB];
         pump_current_multiplier <=
            bank_reg[4][`CUR_MULT_MSB:`CUR_MULT_LSB];
         pump_control_source     <= bank_reg[4][`CTL_SRC_BIT];
         pump_control_field      <=
            bank_reg[4][`CTL_FLD_MSB:`CTL_FLD_LSB];
         detector_edge_sense     <= bank_reg[4][`EDGE_MSB:`EDGE_LSB];
         antibacklash_delay      <= bank_reg[4][`ABL_MSB:`ABL_LSB];

         // Bits 23:12 of word 5 are dropped
         // LO path word
         linearizer_cap_setting <=
            bank_reg[5][`LIN_CAP_MSB:`LIN_CAP_LSB];
         mixer_bias_on          <= bank_reg[5][`MIX_BIAS_BIT];
         synth_on               <= bank_reg[5][`SYNTH_ON_BIT];
         lo_div_select          <= bank_reg[5][`LO_DIV_BIT];
         lo_in_out_select       <= bank_reg[5][`LO_IO_BIT];
         lo_driver_on           <= bank_reg[5][`LO_DRV_BIT];

         // Bits 23:21 of word 6 are dropped
         // oscillator word
         pump_on            <= bank_reg[6][`PUMP_ON_BIT];
         aux_regulator_on   <= bank_reg[6][`AUX_REG_BIT];
         osc_regulator_on   <= bank_reg[6][`OSC_REG_BIT];
         osc_on             <= bank_reg[6][`OSC_ON_BIT];
         osc_switch_ctrl    <= bank_reg[6][`OSC_SW_BIT];
         osc_amplitude      <= bank_reg[6][`OSC_AMP_MSB:`OSC_AMP_LSB];
         band_select_source <= bank_reg[6][`BAND_SRC_BIT];
         band_select_value  <= bank_reg[6][`BAND_MSB:`BAND_LSB];

         // Only bit 22 of word 7 is kept
         // external oscillator word
         ext_osc_on         <= bank_reg[7][`EXT_OSC_BIT];
      end
   end

endmodule // pll_mixer_config_registers
`default_nettype wire

// File: cfg_bank_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Port checker for the config bank
// ----------------------------------------
module cfg_bank_monitor
(
   input wire logic        ref_clk,
   input wire logic        sys_rst,
   input wire logic        clkEn,
   input wire logic        serLoad,
   input wire logic        calStart,
   input wire logic        fracModeActive,
   input wire logic        divide_mode_sel,
   input wire logic [6:0]  int_divide_value,
   input wire logic [10:0] modulus_value,
   input wire logic        synth_on,
   input wire logic [5:0]  band_select_value,
   input wire logic        ext_osc_on
);
   default clocking dc @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   logic [3:0] loadAge;   // Cycles since load pin rose, saturates at F

   // Age restarts on each load edge; saturating avoids wrap aliasing
   always @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
         loadAge <= 4'hF;
      else if ($rose(serLoad))
         loadAge <= 4'h0;
      else if (loadAge != 4'hF)
         loadAge <= loadAge + 4'h1;
   end

   sequence load_edge;
      $rose(serLoad) ##1 clkEn [*8];
   endsequence

   sequence cal_once;
      calStart ##1 !calStart;
   endsequence

   cal_pulse_a: assert property (calStart && clkEn |-> cal_once)
      else $error("calibration start wider than one cycle");
   cal_cause_a: assert property (calStart |-> loadAge inside {[1:6]})
      else $error("calibration start without a recent load");
   no_late_cal_a: assert property (load_edge |-> !calStart)
      else $error("calibration start too late after load");
   int_commit_a: assert property
      ($changed(int_divide_value) |-> loadAge inside {[2:7]})
      else $error("integer field moved without a load");
   ext_commit_a: assert property
      ($changed(ext_osc_on) |-> loadAge inside {[2:7]})
      else $error("external oscillator bit moved without a load");
   mod_cal_a: assert property
      ($changed(modulus_value) |-> $past(calStart) || $past(calStart, 2))
      else $error("modulus load did not start calibration");
   band_nocal_a: assert property
      ($changed(band_select_value) |-> !$past(calStart) && !calStart)
      else $error("band select load started calibration");
   frac_mode_a: assert property
      ($changed(divide_mode_sel) |-> ##[0:1] fracModeActive != divide_mode_sel)
      else $error("fractional flag disagrees with mode bit");
   freeze_a: assert property
      (!clkEn && !calStart |=> !calStart && $stable(synth_on))
      else $error("state moved while clock enable low");
endmodule // cfg_bank_monitor

bind pll_mixer_config_registers cfg_bank_monitor u_cfg_bank_monitor
(
   .ref_clk, .sys_rst, .clkEn, .serLoad, .calStart, .fracModeActive,
   .divide_mode_sel, .int_divide_value, .modulus_value, .synth_on,
   .band_select_value, .ext_osc_on
);
`default_nettype wire

// File: serial_host.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Host model on the three-wire port
// ----------------------------------------
module serial_host
(
   input  wire logic ref_clk,
   output var  logic serClk,
   output var  logic serData,
   output var  logic serLoad
);
   // Idle link: clock parked low, load low
   initial
   begin
      serClk  = 1'b0;
      serData = 1'b0;
      serLoad = 1'b0;
   end

   // Shift nb bits MSB first, 400 ns per bit, then pulse load
   task automatic send(input logic [25:0] w, input int nb);
      begin
         @(posedge ref_clk);
         #5;
         for (int i = nb - 1; i >= 0; i--)
         begin
            serData = w[i];
            #100 serClk = 1'b1;
            #200 serClk = 1'b0;
            #100;
         end
         // Released data line shows the inverse, not the last bit
         serData = ~serData;
         #100 serLoad = 1'b1;
         #400 serLoad = 1'b0;
         #400;
      end
   endtask
endmodule // serial_host
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Self-checking bench for the config bank
// ----------------------------------------
module testbench;
   logic ref_clk = 1'b0;   // 20 MHz reference clock
   logic sys_rst = 1'b1;   // Async reset, held at start
   logic clkEn   = 1'b1;   // Clock enable, dropped once
   wire logic serClk, serData, serLoad;
   logic divide_mode_sel, fracModeActive, calStart, dither_on;
   logic pump_reference_sel, phase_offset_polarity, pump_control_source;
   logic mixer_bias_on, synth_on, lo_div_select, lo_in_out_select;
   logic lo_driver_on, pump_on, aux_regulator_on, osc_regulator_on;
   logic osc_on, osc_switch_ctrl, band_select_source, ext_osc_on;
   logic [1:0] dither_magnitude, ref_path_source, pump_current_multiplier;
   logic [1:0] pump_control_field, detector_edge_sense, antibacklash_delay;
   logic [2:0] ref_input_source;
   logic [3:0] linearizer_cap_setting;
   logic [4:0] phase_offset_multiplier;
   logic [5:0] osc_amplitude, band_select_value;
   logic [6:0] int_divide_value;
   logic [10:0] modulus_value, numerator_value;
   logic [16:0] dither_restart_value;
   logic [23:0] shadow [8];      // Expected register contents
   logic [27:0] notes [$];       // {cal expected, code, word}
   int seed = 99;
   int checked = 0;
   int n_mismatch = 0;
   // Bits each register keeps; reserved bits read back as zero
   logic [23:0] keep [8] = '{24'h00_07F8, 24'h00_3FF8, 24'h00_3FF8,
      24'h7F_FFF8, 24'hFF_FFF8, 24'h00_0FF8, 24'h1F_FFF8, 24'h40_0000};
   int order [7] = '{7, 6, 4, 3, 2, 1, 0};   // Power-up write order

   always #25 ref_clk = ~ref_clk;

   serial_host u_serial_host (.ref_clk, .serClk, .serData, .serLoad);

   pll_mixer_config_registers u_pll_mixer_config_registers
   (
      .ref_clk, .sys_rst, .clkEn, .serClk, .serData, .serLoad,
      .divide_mode_sel, .int_divide_value, .modulus_value,
      .numerator_value, .fracModeActive, .calStart, .dither_magnitude,
      .dither_on, .dither_restart_value, .ref_input_source,
      .ref_path_source, .pump_reference_sel, .phase_offset_polarity,
      .phase_offset_multiplier, .pump_current_multiplier,
      .pump_control_source, .pump_control_field, .detector_edge_sense,
      .antibacklash_delay, .linearizer_cap_setting, .mixer_bias_on,
      .synth_on, .lo_div_select, .lo_in_out_select, .lo_driver_on,
      .pump_on, .aux_regulator_on, .osc_regulator_on, .osc_on,
      .osc_switch_ctrl, .osc_amplitude, .band_select_source,
      .band_select_value, .ext_osc_on
   );

   // Rebuild a register image from the field outputs
   function automatic logic [23:0] view(input logic [2:0] c);
      logic [23:0] v;
      v = 24'h00_0000;
      case (c)
         3'h0: v[10:3] = {divide_mode_sel, int_divide_value};
         3'h1: v[13:3] = modulus_value;
         3'h2: v[13:3] = numerator_value;
         3'h3: v[22:3] = {dither_magnitude, dither_on, dither_restart_value};
         3'h4: v[23:3] = {ref_input_source, ref_path_source,
            pump_reference_sel, phase_offset_polarity,
            phase_offset_multiplier, pump_current_multiplier,
            pump_control_source, pump_control_field, detector_edge_sense,
            antibacklash_delay};
         3'h5: v[11:3] = {linearizer_cap_setting, mixer_bias_on, synth_on,
            lo_div_select, lo_in_out_select, lo_driver_on};
         3'h6: v[20:3] = {pump_on, aux_regulator_on, osc_regulator_on,
            osc_on, osc_switch_ctrl, osc_amplitude, band_select_source,
            band_select_value};
         default: v[22] = ext_osc_on;
      endcase
      return v;
   endfunction

   task automatic check(input string what, input logic [23:0] got,
                        input logic [23:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic complete_run;
      $display("Comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Send one word of nb bits; frozen means clock enable is low
   task automatic write(input logic [23:0] w, input bit frozen, input int nb);
      logic [2:0] c;
      c = w[2:0];
      if (!frozen)
         shadow[c] = w & keep[c];
      notes.push_back({!frozen && c < 3'h3, c, shadow[c]});
      u_serial_host.send({2'($random(seed)), w}, nb);
   endtask

   // All registers must read zero after a reset
   task automatic zero_check;
      for (int c = 0; c < 8; c++)
      begin
         shadow[c] = 24'h00_0000;
         check("reset value", view(3'(c)), 24'h00_0000);
      end
   endtask

   // Each load edge: count calibration pulses, then compare the bank
   always @(posedge serLoad)
   begin : watch
      logic [27:0] n;
      int pulses;
      pulses = 0;
      repeat (8)
      begin
         @(negedge ref_clk);
         pulses += (calStart === 1'b1);
      end
      if (notes.size() == 0)
         check("note queue", 24'h00_0001, 24'h00_0000);
      else
      begin
         n = notes.pop_front();
         check("bank word", view(n[26:24]), n[23:0]);
         check("cal pulses", 24'(pulses), {23'h0, n[27]});
         if (n[26:24] == 3'h0)
            check("frac flag", {23'h0, fracModeActive}, {23'h0, ~n[10]});
      end
   end

   // Hang guard
   initial
   begin
      repeat (100000) @(posedge ref_clk);
      n_mismatch++;
      complete_run();
   end

   initial
   begin
      logic [23:0] w;
      repeat (4) @(posedge ref_clk);
      #5 sys_rst = 1'b0;
      zero_check();
      write(24'h00_0005, 0, 24);
      write(24'h00_0F45, 0, 24);
      foreach (order[k])
         write({21'($random(seed)), 3'(order[k])}, 0, 24);
      // frequency changes write 2, 1, 0
      repeat (3)
         for (int c = 2; c >= 0; c--)
            write({21'($random(seed)), 3'(c)}, 0, 24);
      // Every code with all ones, then random reserved junk
      for (int c = 0; c < 16; c++)
      begin
         w = (c < 8) ? 24'hFF_FFF8 : 24'($random(seed));
         write({w[23:3], 3'(c)}, 0, 24);
      end
      // Two leading extra bits must fall out of the word
      write({21'($random(seed)), 3'h4}, 0, 26);
      // Frozen bank ignores the port
      @(posedge ref_clk);
      #5 clkEn = 1'b0;
      write({21'($random(seed)), 3'h5}, 1, 24);
      #5 clkEn = 1'b1;
      // Reset in mid-run clears everything
      repeat (20) @(posedge ref_clk);
      #5 sys_rst = 1'b1;
      repeat (2) @(posedge ref_clk);
      #5 sys_rst = 1'b0;
      zero_check();
      write({21'($random(seed)), 3'h7}, 0, 24);
      repeat (20) @(posedge ref_clk);
      complete_run();
   end
endmodule // testbench
`default_nettype wire
